// ### hdl/sideband_map.svh
// Purpose: constants for the sideband role logic
// Assumes: nothing
// Notes:   definitions only
`ifndef SIDEBAND_MAP_SVH
`define SIDEBAND_MAP_SVH
`define SB_WIRE_RESET   1'b0
`define SB_ACK_RESET    1'b0
`define SB_SYNC_STAGES  2
`endif

// ### hdl/sideband_pkg.sv
// Purpose: types for the sideband role logic
// Assumes: nothing
// Notes:   one-hot role states
package sideband_pkg;
    typedef enum logic [2:0] {
        ROLE_SECONDARY = 3'b001,
        ROLE_PRIMARY   = 3'b010,
        ROLE_UNUSED    = 3'b100
    } role_e;
endpackage : sideband_pkg

// ### hdl/espi_sideband_role_logic.sv
// Purpose: slave-role selection and sideband pin mapping of an espi bridge
// Assumes: clk is the espi-side clock, reset is the espi reset (sync, high)
// Notes:   the virtual wire transport is outside; this block hands it levels
//
// Contract
// - role_select_in high means primary role, low means secondary role.
// - role_select_in acts continuously, strapped or changed once, never latched.
// - in primary role both boot-load wires are offered as one at the first chance.
// - in primary role the shared pin shows suspend_powerdown_ack; host reset ack goes as a wire.
// - in secondary role the boot-load wires are never sent.
// - in secondary role suspend_warn_out still follows its wire and suspend_ack_in is ignored.
// - with role_select_in low the shared pin shows host reset ack and primary wires are quiet.
// - on a low-then-high select the boot-load wires wait, then go as one at the rise.
// - during a delayed primary start, suspend_ack_in edges seen before is_primary rises are dropped.
// - during a delayed start the shared pin is low as host reset ack, then low as powerdown ack.
// - suspend_warn_out follows the received suspend warning wire.
// - in primary role each edge on suspend_ack_in is sent as the suspend acknowledge wire.
// - with role_select_in high the shared pin mirrors the powerdown ack wire.
// - in secondary role host reset ack rises after a warn rise once lpc and irq are idle.
`timescale 1ns/1ps
`include "sideband_map.svh"
`default_nettype none
module espi_sideband_role_logic
    import sideband_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic role_select_in,
    input  wire logic suspend_ack_in,
    input  wire logic suspend_warning_wire,
    input  wire logic suspend_powerdown_ack,
    input  wire logic host_reset_warn,
    input  wire logic host_reset_ack_int,
    input  wire logic lpc_serirq_idle,
    input  wire logic boot_wire_taken,
    input  wire logic ack_wire_taken,
    output logic      suspend_warn_out,
    output logic      shared_ack_out,
    output logic      is_primary,
    output logic      boot_wire_valid,
    output logic      boot_load_done,
    output logic      boot_load_status,
    output logic      ack_wire_valid,
    output logic      suspend_acknowledge_wire,
    output logic      host_reset_ack_valid,
    output logic      host_reset_ack_wire
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] role_sync_r;
    logic [1:0] role_sync_nxt;
    logic [1:0] ack_sync_r;
    logic [1:0] ack_sync_nxt;
    logic       ack_prev_r;
    logic       ack_prev_nxt;

    always_comb begin
        role_sync_nxt = {role_sync_r[0], role_select_in};
        ack_sync_nxt  = {ack_sync_r[0], suspend_ack_in};
        ack_prev_nxt  = ack_sync_r[1];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            role_sync_r <= 2'h0;
            ack_sync_r  <= 2'h0;
            ack_prev_r  <= `SB_ACK_RESET;
        end else begin
            role_sync_r <= role_sync_nxt;
            ack_sync_r  <= ack_sync_nxt;
            ack_prev_r  <= ack_prev_nxt;
        end
    end

    // ----------------------------------------------------------------
    // role state
    // ----------------------------------------------------------------
    // a high-to-low select is forbidden on the board; we simply follow it
    role_e role_r;
    role_e role_nxt;

    always_comb begin
        case (role_r)
            ROLE_SECONDARY: role_nxt = role_sync_r[1] ? ROLE_PRIMARY : ROLE_SECONDARY;
            ROLE_PRIMARY:   role_nxt = role_sync_r[1] ? ROLE_PRIMARY : ROLE_SECONDARY;
            default:        role_nxt = ROLE_SECONDARY;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            role_r <= ROLE_SECONDARY;
        end else begin
            role_r <= role_nxt;
        end
    end

    // ----------------------------------------------------------------
    // boot-load wires
    // ----------------------------------------------------------------
    // pending until the master takes them, so the first chance is used
    logic boot_sent_r;
    logic boot_sent_nxt;

    always_comb begin
        boot_sent_nxt = boot_sent_r;
        if (role_r == ROLE_PRIMARY && boot_wire_taken) begin
            boot_sent_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            boot_sent_r <= 1'b0;
        end else begin
            boot_sent_r <= boot_sent_nxt;
        end
    end

    assign is_primary       = (role_r == ROLE_PRIMARY);
    assign boot_wire_valid  = is_primary && !boot_sent_r;
    assign boot_load_done   = 1'b1;
    assign boot_load_status = 1'b1;

    // ----------------------------------------------------------------
    // suspend acknowledge wire
    // ----------------------------------------------------------------
    // edges are held pending until taken, not dropped; edges seen before
    // is_primary rises are ignored, so a delayed start loses them
    logic ack_pend_r;
    logic ack_pend_nxt;
    logic ack_lvl_r;
    logic ack_lvl_nxt;
    logic ack_edge;

    always_comb begin
        ack_edge     = is_primary && (ack_sync_r[1] != ack_prev_r);
        ack_pend_nxt = ack_pend_r;
        ack_lvl_nxt  = ack_lvl_r;
        if (ack_wire_taken) begin
            ack_pend_nxt = 1'b0;
        end
        if (ack_edge) begin
            ack_pend_nxt = 1'b1;
            ack_lvl_nxt  = ack_sync_r[1];
        end
        if (!is_primary) begin
            ack_pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_pend_r <= 1'b0;
            ack_lvl_r  <= `SB_ACK_RESET;
        end else begin
            ack_pend_r <= ack_pend_nxt;
            ack_lvl_r  <= ack_lvl_nxt;
        end
    end

    assign ack_wire_valid           = ack_pend_r;
    assign suspend_acknowledge_wire = ack_lvl_r;
    assign host_reset_ack_valid     = is_primary;
    assign host_reset_ack_wire      = host_reset_ack_int;

    // ----------------------------------------------------------------
    // output pins
    // ----------------------------------------------------------------
    logic warn_out_r;
    logic warn_out_nxt;
    logic hra_r;
    logic hra_nxt;
    logic hra_pend_r;
    logic hra_pend_nxt;
    logic warn_prev_r;
    logic warn_prev_nxt;
    logic warn_rise;
    logic shared_r;
    logic shared_nxt;

    // a warn rise is remembered while host_reset_warn stays high until lpc and irq go idle, so a busy bus
    // only delays the ack; a warn fall before idle drops it
    always_comb begin
        warn_out_nxt  = suspend_warning_wire;
        warn_prev_nxt = host_reset_warn;
        warn_rise     = host_reset_warn && !warn_prev_r;
        hra_nxt       = hra_r;
        hra_pend_nxt  = hra_pend_r;
        if (warn_rise) begin
            hra_pend_nxt = 1'b1;
        end
        if (!host_reset_warn) begin
            hra_nxt      = 1'b0;
            hra_pend_nxt = 1'b0;
        end else if (lpc_serirq_idle && (hra_pend_r || warn_rise)) begin
            hra_nxt      = 1'b1;
            hra_pend_nxt = 1'b0;
        end
        if (is_primary) begin
            hra_nxt      = 1'b0;
            hra_pend_nxt = 1'b0;
        end
        if (is_primary) begin
            shared_nxt = suspend_powerdown_ack;
        end else begin
            shared_nxt = hra_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            warn_out_r  <= `SB_WIRE_RESET;
            hra_r       <= 1'b0;
            hra_pend_r  <= 1'b0;
            warn_prev_r <= 1'b0;
            shared_r    <= 1'b0;
        end else begin
            warn_out_r  <= warn_out_nxt;
            hra_r       <= hra_nxt;
            hra_pend_r  <= hra_pend_nxt;
            warn_prev_r <= warn_prev_nxt;
            shared_r    <= shared_nxt;
        end
    end

    assign suspend_warn_out = warn_out_r;
    assign shared_ack_out   = shared_r;
endmodule : espi_sideband_role_logic
`default_nettype wire

// ### dv/board_ack_model.sv
// Purpose: board loop from the warn pin back to the ack pin
// Assumes: clk is the bench clock
// Notes:   lag 0 answers at the next falling edge, larger lags stand for a gating delay
`timescale 1ns/1ps
`default_nettype none
module board_ack_model (
    input  wire logic       clk,
    input  wire logic       warn_pin,
    input  wire logic [3:0] lag,
    output wire logic       ack_pin
);
    logic [15:0] dly_r = 16'h0000;
    // each warn edge comes back as an ack edge lag cycles after the next falling edge, so lag plus half a cycle
    always @(negedge clk) begin
        dly_r <= {dly_r[14:0], warn_pin};
    end
    assign ack_pin = dly_r[lag];
endmodule : board_ack_model
`default_nettype wire

// ### dv/espi_sideband_role_logic_monitor.sv
// Purpose: port checker for the sideband role logic
// Assumes: reset is synchronous, active high
// Notes:   latencies as handed over
`timescale 1ns/1ps
`default_nettype none
module espi_sideband_role_logic_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic role_select_in,
    input wire logic suspend_ack_in,
    input wire logic suspend_warning_wire,
    input wire logic suspend_powerdown_ack,
    input wire logic host_reset_warn,
    input wire logic host_reset_ack_int,
    input wire logic lpc_serirq_idle,
    input wire logic boot_wire_taken,
    input wire logic ack_wire_taken,
    input wire logic suspend_warn_out,
    input wire logic shared_ack_out,
    input wire logic is_primary,
    input wire logic boot_wire_valid,
    input wire logic boot_load_done,
    input wire logic boot_load_status,
    input wire logic ack_wire_valid,
    input wire logic suspend_acknowledge_wire,
    input wire logic host_reset_ack_valid,
    input wire logic host_reset_ack_wire
);
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (reset);
    warn_follow_a: assert property (
        !$past(reset) |-> suspend_warn_out == $past(suspend_warning_wire)) else $error("warn");
    role_rise_a: assert property (
        $rose(role_select_in) |-> ##3 is_primary) else $error("role");
    sec_quiet_a: assert property (
        !is_primary |-> !boot_wire_valid && !ack_wire_valid) else $error("quiet");
    boot_once_a: assert property (
        boot_wire_valid && boot_wire_taken |=> !boot_wire_valid [*8]) else $error("boot");
    boot_pair_a: assert property (
        boot_wire_valid |-> boot_load_done && boot_load_status) else $error("pair");
    shared_pri_a: assert property (
        !$past(reset) && $past(is_primary) |-> shared_ack_out == $past(suspend_powerdown_ack))
        else $error("shared");
    shared_sec_a: assert property (
        !$past(reset) && !$past(is_primary) && !$past(shared_ack_out)
        && !($past(host_reset_warn) && $past(lpc_serirq_idle)) |-> !shared_ack_out)
        else $error("hra");
    ack_edge_a: assert property (
        is_primary && $changed(suspend_ack_in) |-> ##3 ack_wire_valid
        && suspend_acknowledge_wire == $past(suspend_ack_in, 3)) else $error("ack");
    hra_wire_a: assert property (
        host_reset_ack_valid == is_primary && host_reset_ack_wire == host_reset_ack_int)
        else $error("hra wire");
endmodule : espi_sideband_role_logic_monitor
bind espi_sideband_role_logic espi_sideband_role_logic_monitor mon_i (.*);
`default_nettype wire

// ### dv/tb.sv
// Purpose: self-checking bench for the sideband role logic
// Assumes: inputs change at the falling edge
// Notes:   board loop closes warn to ack
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic role_select_in = 1'b0;
    logic suspend_warning_wire = 1'b0;
    logic suspend_powerdown_ack = 1'b0;
    logic host_reset_warn = 1'b0;
    logic host_reset_ack_int = 1'b0;
    logic lpc_serirq_idle = 1'b0;
    logic boot_wire_taken = 1'b0;
    logic ack_wire_taken = 1'b0;
    logic [3:0] lag = 4'h0;
    logic suspend_ack_in, suspend_warn_out, shared_ack_out, is_primary, boot_wire_valid;
    logic boot_load_done, boot_load_status, ack_wire_valid, suspend_acknowledge_wire;
    logic host_reset_ack_valid, host_reset_ack_wire;
    int fails = 0;
    int compares = 0;
    espi_sideband_role_logic espi_sideband_role_logic_i (
        .clk                      (clk),
        .reset                    (reset),
        .role_select_in           (role_select_in),
        .suspend_ack_in           (suspend_ack_in),
        .suspend_warning_wire     (suspend_warning_wire),
        .suspend_powerdown_ack    (suspend_powerdown_ack),
        .host_reset_warn          (host_reset_warn),
        .host_reset_ack_int       (host_reset_ack_int),
        .lpc_serirq_idle          (lpc_serirq_idle),
        .boot_wire_taken          (boot_wire_taken),
        .ack_wire_taken           (ack_wire_taken),
        .suspend_warn_out         (suspend_warn_out),
        .shared_ack_out           (shared_ack_out),
        .is_primary               (is_primary),
        .boot_wire_valid          (boot_wire_valid),
        .boot_load_done           (boot_load_done),
        .boot_load_status         (boot_load_status),
        .ack_wire_valid           (ack_wire_valid),
        .suspend_acknowledge_wire (suspend_acknowledge_wire),
        .host_reset_ack_valid     (host_reset_ack_valid),
        .host_reset_ack_wire      (host_reset_ack_wire)
    );
    board_ack_model board_ack_model_i (.clk(clk), .warn_pin(suspend_warn_out), .lag(lag),
        .ack_pin(suspend_ack_in));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wrap_up;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic do_reset(input logic role);
        reset = 1'b1;
        role_select_in = role;
        cyc(5);
        reset = 1'b0;
    endtask : do_reset
    task automatic sec_role;
        do_reset(1'b0);
        suspend_warning_wire = 1'b1;
        cyc(1);
        chk("warn_out", 1'b1, suspend_warn_out);
        cyc(8);
        chk("ack_valid", 1'b0, ack_wire_valid);
        chk("boot_valid", 1'b0, boot_wire_valid);
        host_reset_warn = 1'b1;
        cyc(3);
        chk("shared", 1'b0, shared_ack_out);
        lpc_serirq_idle = 1'b1;
        cyc(2);
        chk("shared", 1'b1, shared_ack_out);
        host_reset_warn = 1'b0;
        suspend_warning_wire = 1'b0;
        cyc(8);
        chk("shared", 1'b0, shared_ack_out);
    endtask : sec_role
    task automatic delayed_primary;
        role_select_in = 1'b1; // only ever rises
        cyc(2);
        chk("primary", 1'b0, is_primary);
        cyc(1);
        chk("primary", 1'b1, is_primary);
        chk("boot_valid", 1'b1, boot_wire_valid);
        chk("boot_bits", 1'b1, boot_load_done & boot_load_status);
        chk("shared", 1'b0, shared_ack_out);
        suspend_powerdown_ack = 1'b1;
        host_reset_ack_int = 1'b1;
        cyc(2);
        chk("shared", 1'b1, shared_ack_out);
        chk("hra_wire", 1'b1, host_reset_ack_valid & host_reset_ack_wire);
        boot_wire_taken = 1'b1;
        cyc(1);
        boot_wire_taken = 1'b0;
        cyc(5);
        chk("boot_valid", 1'b0, boot_wire_valid);
    endtask : delayed_primary
    task automatic ack_hshake(input logic [3:0] d);
        int n;
        // let the loop settle so a lag change shows no stray edge
        cyc(16);
        lag = d;
        suspend_warning_wire = ~suspend_warning_wire;
        n = 0;
        while (ack_wire_valid !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        if (ack_wire_valid !== 1'b1) begin
            fails++;
            wrap_up();
        end
        chk("ack_wire", suspend_warning_wire, suspend_acknowledge_wire);
        ack_wire_taken = 1'b1;
        cyc(1);
        ack_wire_taken = 1'b0;
        chk("ack_valid", 1'b0, ack_wire_valid);
    endtask : ack_hshake
    initial begin
        sec_role();
        delayed_primary();
        ack_hshake(4'h0);
        ack_hshake(4'h9);
        do_reset(1'b1);
        cyc(3);
        chk("primary", 1'b1, is_primary);
        chk("boot_valid", 1'b1, boot_wire_valid);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
